//--- sfw_host.sv
// sfw_host: serial bus host model, mode 0, 800 ns link clock.
// assumes a 100 ns system clock; clock stands low between frames.
`timescale 1ns/10ps
module sfw_host (
    input wire logic clk, // system clock
    input wire logic so, // serial data from device
    output logic cs_n, // chip select, active low
    output logic sck, // serial clock
    output logic si // serial data to device
);
    logic [7:0] rx_reg = 8'h00;
    initial begin
        cs_n = 1'b1;
        sck = 1'b0;
        si = 1'b0;
    end
    task automatic half();
        repeat (4) @(posedge clk);
        #1;
    endtask
    // tail adds bits past the last byte, leaving the frame off the byte grid
    task automatic frame(input logic [7:0] q[$], input int tail);
        int n;
        n = q.size() * 8 + tail;
        @(posedge clk);
        #1;
        cs_n = 1'b0;
        for (int i = 0; i < n; i++) begin
            si = (i / 8 < q.size()) ? q[i / 8][7 - i % 8] : 1'b1;
            half();
            sck = 1'b1;
            half();
            // sampled late: data out lags the falling edge by several clocks
            rx_reg = {rx_reg[6:0], so};
            sck = 1'b0;
        end
        half();
        cs_n = 1'b1;
        si = ~si;
        repeat (8) @(posedge clk);
        #1;
    endtask
endmodule // sfw_host

//--- sfw_monitor.sv
// sfw_monitor: port checks for the serial flash write control.
// assumes one clock domain; bound to every sfw_write_ctrl instance.
`timescale 1ns/10ps
module sfw_chk import sfw_pkg::*; #(
    parameter int SMALL_ERASE_CYCLES = 1, // small sector erase duration
    parameter int SECTOR_ERASE_CYCLES = 1, // sector erase duration
    parameter int CHIP_ERASE_CYCLES = 1, // chip erase duration
    parameter int PROGRAM_CYCLES = 1, // page program duration
    parameter int STATUS_WRITE_CYCLES = 1 // status write duration
) (
    input wire logic CLK, // system clock
    input wire logic RST, // async reset
    input wire logic CS_N, // chip select
    input wire logic SO_OE, // data out enable
    input wire logic [7:0] STATUS_WORD, // status word
    input wire logic POWER_DOWN, // power-down state
    input wire logic OP_START, // operation start pulse
    input wire sfw_op_t OP_REQ // operation request
);
    default clocking @(posedge CLK); endclocking
    default disable iff (RST);
    // ----
    // busy length helper
    // ----
    int busy_cnt_reg;
    int busy_exp;
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            busy_cnt_reg <= 0;
        end else if (OP_START) begin
            busy_cnt_reg <= 1;
        end else if (STATUS_WORD[0]) begin
            busy_cnt_reg <= busy_cnt_reg + 1;
        end
    end
    always_comb begin
        case (OP_REQ.kind)
            OP_SMALL_ERASE: busy_exp = SMALL_ERASE_CYCLES;
            OP_SECTOR_ERASE: busy_exp = SECTOR_ERASE_CYCLES;
            OP_CHIP_ERASE: busy_exp = CHIP_ERASE_CYCLES;
            OP_PROGRAM: busy_exp = PROGRAM_CYCLES;
            default: busy_exp = STATUS_WRITE_CYCLES;
        endcase
    end
    chk_busy_cause: assert property ($rose(STATUS_WORD[0]) |-> OP_START)
        else $error("busy rose without a start");
    chk_start_busy: assert property (OP_START |-> STATUS_WORD[0])
        else $error("start without busy");
    chk_start_wen: assert property (OP_START |-> $past(STATUS_WORD[1]))
        else $error("start with write latch clear");
    chk_done_wen: assert property ($fell(STATUS_WORD[0]) |-> !STATUS_WORD[1])
        else $error("write latch kept after completion");
    chk_busy_len: assert property ($fell(STATUS_WORD[0]) |-> busy_cnt_reg == busy_exp)
        else $error("busy length wrong");
    chk_chip_level: assert property (OP_START && OP_REQ.kind == OP_CHIP_ERASE |-> STATUS_WORD[4:2] == 3'h0)
        else $error("chip erase under protection");
    chk_top_sector: assert property (OP_START && OP_REQ.kind == OP_SECTOR_ERASE && STATUS_WORD[5:2] == 4'h1
        |-> OP_REQ.addr[19:16] != 4'hf)
        else $error("erase in protected top range");
    chk_rsv_zero: assert property (STATUS_WORD[6] == 1'b0)
        else $error("reserved bit set");
    chk_pd_quiet: assert property (POWER_DOWN |-> !OP_START && $stable(STATUS_WORD[1]))
        else $error("activity in power-down");
    chk_pd_idle: assert property ($rose(POWER_DOWN) |-> !$past(STATUS_WORD[0]))
        else $error("power-down entered while busy");
    chk_so_off: assert property (CS_N [*6] |-> !SO_OE)
        else $error("data out driven while deselected");
endmodule // sfw_chk

bind sfw_write_ctrl sfw_chk #(.SMALL_ERASE_CYCLES(SMALL_ERASE_CYCLES), .SECTOR_ERASE_CYCLES(SECTOR_ERASE_CYCLES),
    .CHIP_ERASE_CYCLES(CHIP_ERASE_CYCLES), .PROGRAM_CYCLES(PROGRAM_CYCLES),
    .STATUS_WRITE_CYCLES(STATUS_WRITE_CYCLES)) u_chk (.CLK(CLK), .RST(RST), .CS_N(CS_N), .SO_OE(SO_OE),
    .STATUS_WORD(STATUS_WORD), .POWER_DOWN(POWER_DOWN), .OP_START(OP_START), .OP_REQ(OP_REQ));

//--- sfw_page_buf.sv
// sfw_page_buf: 256 x 8 page load buffer with registered read data.
// assumes one clock; write and read ports are independent.
`timescale 1ns/10ps
module sfw_page_buf import sfw_pkg::*; (
    input wire logic clk, // system clock
    input wire logic rst, // async reset, active high
    input wire logic wr_en, // write strobe
    input wire logic [7:0] wr_addr, // write index
    input wire logic [7:0] wr_data, // write byte
    input wire logic [7:0] rd_addr, // read index
    output logic [7:0] rd_data // read byte, one cycle after rd_addr
);

    logic [7:0] mem_reg [PAGE_BYTES];

    always_ff @(posedge clk) begin
        if (wr_en) begin
            mem_reg[wr_addr] <= wr_data;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rd_data <= 8'h00;
        end else begin
            rd_data <= mem_reg[rd_addr];
        end
    end

endmodule // sfw_page_buf

//--- sfw_pkg.sv
// sfw_pkg: constants, command codes and carrier types of the serial flash write control.
// assumes a 10 MHz system clock; all timing counts are derived from it here.
package sfw_pkg;

    // ----------------------------------------------------------------
    // clock and operation timing
    // ----------------------------------------------------------------
    localparam int CLK_HZ = 10_000_000;
    localparam int CYC_PER_US = CLK_HZ / 1_000_000;
    localparam int SMALL_ERASE_TIME_US = 150_000;
    localparam int SECTOR_ERASE_TIME_US = 250_000;
    localparam int CHIP_ERASE_TIME_US = 6_000_000;
    localparam int PROGRAM_TIME_US = 1_000;
    localparam int STATUS_WRITE_TIME_US = 10_000;
    localparam int SMALL_ERASE_CYC = SMALL_ERASE_TIME_US * CYC_PER_US;
    localparam int SECTOR_ERASE_CYC = SECTOR_ERASE_TIME_US * CYC_PER_US;
    localparam int CHIP_ERASE_CYC = CHIP_ERASE_TIME_US * CYC_PER_US;
    localparam int PROGRAM_CYC = PROGRAM_TIME_US * CYC_PER_US;
    localparam int STATUS_WRITE_CYC = STATUS_WRITE_TIME_US * CYC_PER_US;

    // ----------------------------------------------------------------
    // command codes
    // ----------------------------------------------------------------
    localparam logic [7:0] CMD_WR_ENABLE = 8'h06;
    localparam logic [7:0] CMD_WR_DISABLE = 8'h04;
    localparam logic [7:0] CMD_POWER_DOWN = 8'hb9;
    localparam logic [7:0] CMD_PD_EXIT = 8'hab;
    localparam logic [7:0] CMD_SMALL_ERASE_A = 8'h20;
    localparam logic [7:0] CMD_SMALL_ERASE_B = 8'hd7;
    localparam logic [7:0] CMD_SECTOR_ERASE = 8'hd8;
    localparam logic [7:0] CMD_CHIP_ERASE_A = 8'h60;
    localparam logic [7:0] CMD_CHIP_ERASE_B = 8'hc7;
    localparam logic [7:0] CMD_PROGRAM = 8'h02;
    localparam logic [7:0] CMD_STATUS_READ = 8'h05;
    localparam logic [7:0] CMD_STATUS_WRITE = 8'h01;
    localparam logic [7:0] CMD_NONE = 8'h00;

    // ----------------------------------------------------------------
    // status word layout and reset values
    // ----------------------------------------------------------------
    localparam int ST_BUSY = 0;
    localparam int ST_WEN = 1;
    localparam int ST_LVL_LO = 2;
    localparam int ST_LVL_HI = 4;
    localparam int ST_BOTTOM = 5;
    localparam int ST_LOCK = 7;
    localparam logic [2:0] LVL_RESET = 3'h0;
    localparam logic BOTTOM_RESET = 1'b0;
    localparam logic LOCK_RESET = 1'b0;
    localparam logic RSV_BIT = 1'b0;
    localparam logic [2:0] LVL_NONE = 3'h0;
    localparam logic [2:0] LVL_ALL = 3'h5;

    // ----------------------------------------------------------------
    // frame and address geometry
    // ----------------------------------------------------------------
    localparam logic [2:0] BIT_LAST = 3'h7;
    localparam logic [2:0] IX_CMD = 3'h0;
    localparam logic [2:0] IX_ONE_BYTE = 3'h1;
    localparam logic [2:0] IX_TWO_BYTES = 3'h2;
    localparam logic [2:0] IX_DATA = 3'h4;
    localparam logic [8:0] PAGE_BYTES = 9'h100;
    localparam logic [19:0] ARRAY_LO = 20'h00000;
    localparam logic [19:0] ARRAY_HI = 20'hfffff;
    localparam logic [20:0] ARRAY_SIZE = 21'h100000;
    localparam logic [20:0] PROT_UNIT = 21'h010000;
    localparam logic [19:0] MASK_PAGE = 20'h000ff;
    localparam logic [19:0] MASK_SMALL = 20'h00fff;
    localparam logic [19:0] MASK_SECTOR = 20'h0ffff;

    // ----------------------------------------------------------------
    // carrier types
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        OP_NONE, OP_SMALL_ERASE, OP_SECTOR_ERASE, OP_CHIP_ERASE, OP_PROGRAM, OP_STATUS_WRITE
    } sfw_op_kind_t;

    typedef struct packed {
        sfw_op_kind_t kind;
        logic [19:0] addr;
        logic [8:0] len;
    } sfw_op_t;

    typedef struct packed {
        logic en;
        logic [19:0] lo;
        logic [19:0] hi;
    } sfw_range_t;

endpackage

//--- sfw_write_ctrl.sv
// sfw_write_ctrl: serial bus command decoder, status word and write sequencer.
// assumes CS_N, SCK, SI and WP_N arrive asynchronously; SCK is much slower than CLK.
`timescale 1ns/10ps

module sfw_write_ctrl import sfw_pkg::*; #(
    parameter int SMALL_ERASE_CYCLES = SMALL_ERASE_CYC, // small sector erase duration
    parameter int SECTOR_ERASE_CYCLES = SECTOR_ERASE_CYC, // sector erase duration
    parameter int CHIP_ERASE_CYCLES = CHIP_ERASE_CYC, // chip erase duration
    parameter int PROGRAM_CYCLES = PROGRAM_CYC, // page program duration
    parameter int STATUS_WRITE_CYCLES = STATUS_WRITE_CYC // status write duration
) (
    input wire logic CLK, // system clock
    input wire logic RST, // async reset, active high
    input wire logic CS_N, // chip select pin, active low
    input wire logic SCK, // serial clock pin
    input wire logic SI, // serial data in pin
    input wire logic WP_N, // write protect pin, active low
    output logic SO, // serial data out
    output logic SO_OE, // serial data out enable
    output logic [7:0] STATUS_WORD, // live status word
    output logic POWER_DOWN, // power-down state
    output logic OP_START, // one-cycle pulse: array operation begins
    output sfw_op_t OP_REQ, // operation kind, address, length
    input wire logic [7:0] BUF_RADDR, // page buffer read index
    output logic [7:0] BUF_RDATA // page buffer read data
);

    // ----------------------------------------------------------------
    // pin synchronisers
    // ----------------------------------------------------------------
    logic cs_n_s1, cs_n_s2, cs_n_d;
    logic sck_s1, sck_s2, sck_d;
    logic si_s1, si_s2;
    logic wp_n_s1, wp_n_s2;

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            cs_n_s1 <= 1'b1;
            cs_n_s2 <= 1'b1;
            cs_n_d <= 1'b1;
            sck_s1 <= 1'b0;
            sck_s2 <= 1'b0;
            sck_d <= 1'b0;
            si_s1 <= 1'b0;
            si_s2 <= 1'b0;
            wp_n_s1 <= 1'b1;
            wp_n_s2 <= 1'b1;
        end else begin
            cs_n_s1 <= CS_N;
            cs_n_s2 <= cs_n_s1;
            cs_n_d <= cs_n_s2;
            sck_s1 <= SCK;
            sck_s2 <= sck_s1;
            sck_d <= sck_s2;
            si_s1 <= SI;
            si_s2 <= si_s1;
            wp_n_s1 <= WP_N;
            wp_n_s2 <= wp_n_s1;
        end
    end

    logic cs_active, cs_rise, sck_rise, sck_fall;
    assign cs_active = ~cs_n_s2;
    assign cs_rise = cs_n_s2 & ~cs_n_d;
    assign sck_rise = sck_s2 & ~sck_d;
    assign sck_fall = ~sck_s2 & sck_d;

    // ----------------------------------------------------------------
    // state registers and helpers
    // ----------------------------------------------------------------
    logic busy_reg, wen_reg, pd_reg, lock_reg, bottom_reg;
    logic [2:0] lvl_reg;
    logic [31:0] timer_reg;
    sfw_op_t op_reg;
    logic [7:0] sw_pend_reg;
    logic [7:0] status_word;

    // bit 6 is reserved and always reads zero
    assign status_word = {lock_reg, RSV_BIT, bottom_reg, lvl_reg, wen_reg, busy_reg};

    function automatic sfw_range_t prot_range(input logic [2:0] lvl, input logic bottom);
        logic [20:0] span;
        span = PROT_UNIT << (lvl - 3'h1);
        prot_range = '0;
        if (lvl == LVL_NONE) begin
            prot_range.en = 1'b0;
        end else if (lvl >= LVL_ALL) begin
            prot_range = '{en: 1'b1, lo: ARRAY_LO, hi: ARRAY_HI};
        end else if (bottom) begin
            prot_range = '{en: 1'b1, lo: ARRAY_LO, hi: span[19:0] - 20'h1};
        end else begin
            prot_range = '{en: 1'b1, lo: 20'(ARRAY_SIZE - span), hi: ARRAY_HI};
        end
    endfunction

    // true when any byte of the aligned block holding base is protected
    function automatic logic prot_hit(input sfw_range_t r, input logic [19:0] base, input logic [19:0] mask);
        logic [19:0] blk_lo, blk_hi;
        blk_lo = base & ~mask;
        blk_hi = base | mask;
        prot_hit = r.en && (blk_lo <= r.hi) && (blk_hi >= r.lo);
    endfunction

    function automatic logic [31:0] op_cycles(input sfw_op_kind_t kind);
        unique case (kind)
            OP_SMALL_ERASE: op_cycles = 32'(SMALL_ERASE_CYCLES);
            OP_SECTOR_ERASE: op_cycles = 32'(SECTOR_ERASE_CYCLES);
            OP_CHIP_ERASE: op_cycles = 32'(CHIP_ERASE_CYCLES);
            OP_PROGRAM: op_cycles = 32'(PROGRAM_CYCLES);
            OP_STATUS_WRITE: op_cycles = 32'(STATUS_WRITE_CYCLES);
            default: op_cycles = 32'h1;
        endcase
    endfunction

    // ----------------------------------------------------------------
    // serial frame capture
    // ----------------------------------------------------------------
    logic [2:0] bit_ix_reg, byte_ix_reg;
    logic [6:0] shift_reg;
    logic [7:0] cmd_reg, sw_data_reg, wr_ix_reg;
    logic [23:0] addr_reg;
    logic [8:0] data_cnt_reg;
    logic [7:0] byte_in;
    logic byte_done;

    assign byte_in = {shift_reg, si_s2};
    assign byte_done = cs_active & sck_rise & (bit_ix_reg == BIT_LAST);

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            bit_ix_reg <= 3'h0;
            byte_ix_reg <= 3'h0;
            shift_reg <= 7'h00;
            cmd_reg <= CMD_NONE;
            addr_reg <= 24'h000000;
            sw_data_reg <= 8'h00;
            wr_ix_reg <= 8'h00;
            data_cnt_reg <= 9'h000;
        end else if (!cs_active) begin
            bit_ix_reg <= 3'h0;
            byte_ix_reg <= 3'h0;
            cmd_reg <= CMD_NONE;
            data_cnt_reg <= 9'h000;
        end else if (sck_rise) begin
            shift_reg <= byte_in[6:0];
            bit_ix_reg <= bit_ix_reg + 3'h1;
            if (bit_ix_reg == BIT_LAST) begin
                if (byte_ix_reg != IX_DATA) begin
                    byte_ix_reg <= byte_ix_reg + 3'h1;
                end
                if (byte_ix_reg == IX_CMD) begin
                    cmd_reg <= byte_in;
                end else if (byte_ix_reg < IX_DATA) begin
                    addr_reg <= {addr_reg[15:0], byte_in};
                end
                if (byte_ix_reg == IX_ONE_BYTE) begin
                    sw_data_reg <= byte_in;
                end
                if (byte_ix_reg == IX_DATA) begin
                    // index wraps in the page so the newest 256 bytes survive
                    wr_ix_reg <= wr_ix_reg + 8'h01;
                    if (data_cnt_reg != PAGE_BYTES) begin
                        data_cnt_reg <= data_cnt_reg + 9'h001;
                    end
                end else begin
                    wr_ix_reg <= byte_in;
                end
            end
        end
    end

    // busy keeps the buffer stable for the array back end
    logic buf_we;
    assign buf_we = byte_done & (byte_ix_reg == IX_DATA) & (cmd_reg == CMD_PROGRAM) & ~busy_reg & ~pd_reg;

    sfw_page_buf u_page_buf (
        .clk(CLK),
        .rst(RST),
        .wr_en(buf_we),
        .wr_addr(wr_ix_reg),
        .wr_data(byte_in),
        .rd_addr(BUF_RADDR),
        .rd_data(BUF_RDATA)
    );

    // ----------------------------------------------------------------
    // command decision at chip select rise
    // ----------------------------------------------------------------
    logic accept, one_byte, addr_only, sw_locked;
    sfw_range_t prot;
    sfw_op_t next_op;
    logic set_wen, clr_wen, enter_pd;

    // commands other than status read are refused while busy; all but the exit command are refused while powered down
    assign accept = cs_rise & ~busy_reg & ~pd_reg & (bit_ix_reg == 3'h0);
    assign one_byte = byte_ix_reg == IX_ONE_BYTE;
    assign addr_only = (byte_ix_reg == IX_DATA) & (data_cnt_reg == 9'h000);
    assign sw_locked = lock_reg & ~wp_n_s2;
    assign prot = prot_range(lvl_reg, bottom_reg);

    always_comb begin
        next_op = '{kind: OP_NONE, addr: addr_reg[19:0], len: data_cnt_reg};
        set_wen = 1'b0;
        clr_wen = 1'b0;
        enter_pd = 1'b0;
        if (accept) begin
            unique case (cmd_reg)
                CMD_WR_ENABLE: set_wen = one_byte;
                CMD_WR_DISABLE: clr_wen = one_byte;
                CMD_POWER_DOWN: enter_pd = one_byte;
                CMD_SMALL_ERASE_A, CMD_SMALL_ERASE_B: begin
                    if (addr_only && wen_reg && !prot_hit(prot, addr_reg[19:0], MASK_SMALL)) begin
                        next_op.kind = OP_SMALL_ERASE;
                    end
                end
                CMD_SECTOR_ERASE: begin
                    if (addr_only && wen_reg && !prot_hit(prot, addr_reg[19:0], MASK_SECTOR)) begin
                        next_op.kind = OP_SECTOR_ERASE;
                    end
                end
                CMD_CHIP_ERASE_A, CMD_CHIP_ERASE_B: begin
                    if (one_byte && wen_reg && lvl_reg == LVL_NONE) begin
                        next_op.kind = OP_CHIP_ERASE;
                        next_op.addr = ARRAY_LO;
                    end
                end
                CMD_PROGRAM: begin
                    // no whole data byte means no program at all
                    if (byte_ix_reg == IX_DATA && data_cnt_reg != 9'h000 && wen_reg
                        && !prot_hit(prot, addr_reg[19:0], MASK_PAGE)) begin
                        next_op.kind = OP_PROGRAM;
                    end
                end
                CMD_STATUS_WRITE: begin
                    // a second data byte makes the frame invalid
                    if (byte_ix_reg == IX_TWO_BYTES && wen_reg && !sw_locked) begin
                        next_op.kind = OP_STATUS_WRITE;
                    end
                end
                default: next_op.kind = OP_NONE;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // write sequencer
    // ----------------------------------------------------------------
    logic op_done;
    assign op_done = busy_reg & (timer_reg == 32'h0);

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            busy_reg <= 1'b0;
            timer_reg <= 32'h0;
            op_reg <= '{kind: OP_NONE, addr: ARRAY_LO, len: 9'h000};
            sw_pend_reg <= 8'h00;
            OP_START <= 1'b0;
        end else begin
            OP_START <= 1'b0;
            if (next_op.kind != OP_NONE) begin
                // starts only at chip select rise, ends on the timer
                busy_reg <= 1'b1;
                timer_reg <= op_cycles(next_op.kind) - 32'h1;
                op_reg <= next_op;
                sw_pend_reg <= sw_data_reg;
                OP_START <= 1'b1;
            end else if (op_done) begin
                busy_reg <= 1'b0;
            end else if (busy_reg) begin
                timer_reg <= timer_reg - 32'h1;
            end
        end
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            wen_reg <= 1'b0;
        end else if (op_done) begin
            // only a completed operation or write disable clears the latch, so refused writes keep it
            wen_reg <= 1'b0;
        end else if (set_wen) begin
            wen_reg <= 1'b1;
        end else if (clr_wen) begin
            wen_reg <= 1'b0;
        end
    end

    // new protection takes effect when the status write completes
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            lvl_reg <= LVL_RESET;
            bottom_reg <= BOTTOM_RESET;
            lock_reg <= LOCK_RESET;
        end else if (op_done && op_reg.kind == OP_STATUS_WRITE) begin
            lvl_reg <= sw_pend_reg[ST_LVL_HI:ST_LVL_LO];
            bottom_reg <= sw_pend_reg[ST_BOTTOM];
            lock_reg <= sw_pend_reg[ST_LOCK];
        end
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            pd_reg <= 1'b0;
        end else if (pd_reg && byte_done && byte_ix_reg == IX_CMD && byte_in == CMD_PD_EXIT) begin
            pd_reg <= 1'b0;
        end else if (enter_pd) begin
            pd_reg <= 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // status read output
    // ----------------------------------------------------------------
    logic [2:0] stat_ix_reg;
    logic stat_mode;
    assign stat_mode = cs_active & (cmd_reg == CMD_STATUS_READ) & (byte_ix_reg != IX_CMD) & ~pd_reg;

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            stat_ix_reg <= BIT_LAST;
            SO <= 1'b0;
            SO_OE <= 1'b0;
        end else if (!cs_active) begin
            stat_ix_reg <= BIT_LAST;
            SO <= 1'b0;
            SO_OE <= 1'b0;
        end else if (stat_mode && sck_fall) begin
            // index wraps from bit 0 back to bit 7 while clocks continue
            SO <= status_word[stat_ix_reg];
            SO_OE <= 1'b1;
            stat_ix_reg <= stat_ix_reg - 3'h1;
        end
    end

    assign STATUS_WORD = status_word;
    assign POWER_DOWN = pd_reg;
    assign OP_REQ = op_reg;

endmodule // sfw_write_ctrl

//--- tb.sv
// tb: self-checking bench for the serial flash write control.
// assumes short operation counts; the host model drives the serial pins.
`timescale 1ns/10ps
`define CHK(nm, exp, got) begin checks_done++; if ((got) !== (exp)) begin num_errors++; \
    $display("unexpected %s: expected %h seen %h", nm, exp, got); end end
module tb import sfw_pkg::*;;
    logic CLK = 1'b0;
    logic RST = 1'b1;
    logic WP_N = 1'b1;
    logic [7:0] BUF_RADDR = 8'h00;
    logic CS_N, SCK, SI, SO, SO_OE, POWER_DOWN, OP_START;
    logic [7:0] STATUS_WORD, BUF_RDATA;
    sfw_op_t OP_REQ, last_op;
    int num_errors = 0, checks_done = 0, starts = 0;
    logic [7:0] ecmd[5] = '{CMD_CHIP_ERASE_A, CMD_CHIP_ERASE_B, CMD_SMALL_ERASE_A, CMD_SMALL_ERASE_B, CMD_SECTOR_ERASE};
    sfw_op_kind_t ekind[5] = '{OP_CHIP_ERASE, OP_CHIP_ERASE, OP_SMALL_ERASE, OP_SMALL_ERASE, OP_SECTOR_ERASE};
    logic [7:0] pst[7] = '{8'h47, 8'h04, 8'h24, 8'h24, 8'h30, 8'h3c, 8'h00};
    logic [7:0] padr[7] = '{8'h0f, 8'h0e, 8'h00, 8'h01, 8'h07, 8'h0f, 8'h0f};
    logic pok[7] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1};
    logic [7:0] pdat[3] = '{8'ha1, 8'hb2, 8'hc3};
    always #50 CLK = ~CLK;
    always @(posedge CLK) begin
        if (OP_START === 1'b1) begin
            starts <= starts + 1;
            last_op <= OP_REQ;
        end
    end
    sfw_host host (.clk(CLK), .so(SO), .cs_n(CS_N), .sck(SCK), .si(SI));
    sfw_write_ctrl #(.SMALL_ERASE_CYCLES(40), .SECTOR_ERASE_CYCLES(50), .CHIP_ERASE_CYCLES(150),
        .PROGRAM_CYCLES(30), .STATUS_WRITE_CYCLES(20)) dut (.CLK(CLK), .RST(RST), .CS_N(CS_N), .SCK(SCK),
        .SI(SI), .WP_N(WP_N), .SO(SO), .SO_OE(SO_OE), .STATUS_WORD(STATUS_WORD), .POWER_DOWN(POWER_DOWN),
        .OP_START(OP_START), .OP_REQ(OP_REQ), .BUF_RADDR(BUF_RADDR), .BUF_RDATA(BUF_RDATA));
    task automatic report_and_stop();
        $display("checks %0d errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic wait_idle();
        int i;
        for (i = 0; i < 200 && STATUS_WORD[0] !== 1'b0; i++) begin
            @(posedge CLK);
        end
        #1;
        if (STATUS_WORD[0] !== 1'b0) begin
            `CHK("busy timeout", 1'b0, STATUS_WORD[0])
            report_and_stop();
        end
    endtask
    initial begin
        int s0;
        repeat (12) @(posedge CLK);
        #1;
        RST = 1'b0;
        `CHK("status at reset", 8'h00, STATUS_WORD)
        host.frame('{CMD_PROGRAM, 8'h00, 8'h10, 8'h00, 8'h55}, 0);
        `CHK("program without latch", 0, starts)
        host.frame('{CMD_WR_ENABLE}, 0);
        `CHK("latch set", 1'b1, STATUS_WORD[1])
        host.frame('{CMD_WR_DISABLE}, 0);
        `CHK("latch clear", 1'b0, STATUS_WORD[1])
        // every erase code, erasing before the page program below
        foreach (ecmd[i]) begin
            host.frame('{CMD_WR_ENABLE}, 0);
            if (i < 2) host.frame('{ecmd[i]}, 0);
            else host.frame('{ecmd[i], 8'hf3, 8'h45, 8'h67}, 0);
            `CHK("erase busy", 1'b1, STATUS_WORD[0])
            `CHK("erase kind", ekind[i], last_op.kind)
            if (i > 1) `CHK("erase addr", 20'h34567, last_op.addr)
            if (i == 0) host.frame('{CMD_POWER_DOWN}, 0);
            `CHK("power down while busy", 1'b0, POWER_DOWN)
            wait_idle();
            `CHK("latch after erase", 1'b0, STATUS_WORD[1])
        end
        host.frame('{CMD_WR_ENABLE}, 0);
        host.frame('{CMD_PROGRAM, 8'h0a, 8'h12, 8'hfe, 8'ha1, 8'hb2, 8'hc3}, 0);
        `CHK("program kind", OP_PROGRAM, last_op.kind)
        `CHK("program addr", 20'ha12fe, last_op.addr)
        `CHK("program len", 9'h003, last_op.len)
        foreach (pdat[i]) begin
            BUF_RADDR = 8'hfe + 8'(i);
            repeat (2) @(posedge CLK);
            #1;
            `CHK("page data", pdat[i], BUF_RDATA)
        end
        wait_idle();
        s0 = starts;
        host.frame('{CMD_WR_ENABLE}, 0);
        host.frame('{CMD_PROGRAM, 8'h00, 8'h20, 8'h00, 8'h11}, 3);
        `CHK("partial byte program", s0, starts)
        `CHK("latch kept", 1'b1, STATUS_WORD[1])
        foreach (pst[i]) begin
            host.frame('{CMD_WR_ENABLE}, 0);
            host.frame('{CMD_STATUS_WRITE, pst[i]}, 0);
            wait_idle();
            `CHK("status word", pst[i] & 8'hbc, STATUS_WORD)
            host.frame('{CMD_WR_ENABLE}, 0);
            s0 = starts;
            host.frame('{CMD_SECTOR_ERASE, padr[i], 8'h00, 8'h00}, 0);
            `CHK("protect decode", s0 + pok[i], starts)
            wait_idle();
            `CHK("latch after erase try", !pok[i], STATUS_WORD[1])
            if (!pok[i]) host.frame('{CMD_CHIP_ERASE_A}, 0);
            `CHK("chip erase under protection", s0 + pok[i], starts)
        end
        host.frame('{CMD_WR_ENABLE}, 0);
        host.frame('{CMD_STATUS_WRITE, 8'h80}, 0);
        wait_idle();
        WP_N = 1'b0;
        host.frame('{CMD_WR_ENABLE}, 0);
        host.frame('{CMD_STATUS_WRITE, 8'h04}, 0);
        `CHK("locked status", 8'h82, STATUS_WORD)
        host.frame('{CMD_STATUS_READ, 8'h00}, 0);
        `CHK("status read", 8'h82, host.rx_reg)
        WP_N = 1'b1;
        host.frame('{CMD_STATUS_WRITE, 8'h00}, 0);
        wait_idle();
        `CHK("unlocked status", 8'h00, STATUS_WORD)
        host.frame('{CMD_POWER_DOWN}, 0);
        `CHK("power down", 1'b1, POWER_DOWN)
        host.frame('{CMD_WR_ENABLE}, 0);
        `CHK("latch in power down", 1'b0, STATUS_WORD[1])
        host.frame('{CMD_PD_EXIT}, 0);
        `CHK("power up", 1'b0, POWER_DOWN)
        report_and_stop();
    end
endmodule // tb
